// [rtl/cise_map.vh]
// Opcode classes, field positions, reset values and cycle counts of the execution slice
`ifndef CISE_MAP_VH
`define CISE_MAP_VH

// Instruction classes, opcode bits 13:8
`define CISE_OP_NOP        6'h00
`define CISE_OP_ORL        6'h01
`define CISE_OP_ORF        6'h02
`define CISE_OP_INCREMENT_FILE_OP       6'h03
`define CISE_OP_LSL        6'h04
`define CISE_OP_LSR        6'h05
`define CISE_OP_MOVE_FILE_OP       6'h06
`define CISE_OP_ILOAD      6'h07
`define CISE_OP_ISTORE     6'h08
`define CISE_OP_ILOADK     6'h09
`define CISE_OP_ISTOREK    6'h0a
`define CISE_OP_LDBANK     6'h0b
`define CISE_OP_LDPAGE     6'h0c
`define CISE_OP_LDACC      6'h0d
`define CISE_OP_STACC      6'h0e
`define CISE_OP_OPTION     6'h0f
`define CISE_OP_RESET      6'h10
`define CISE_OP_RETFI      6'h11
`define CISE_OP_RETURN     6'h12
`define CISE_OP_RETLIT     6'h13
`define CISE_OP_RLC        6'h14
`define CISE_OP_RRC        6'h15

// Field positions inside the 14-bit instruction word
`define CISE_CLASS_HI      13
`define CISE_CLASS_LO      8
`define CISE_DEST_BIT      7
`define CISE_PTR_SEL_BIT   6
`define CISE_MODE_HI       1
`define CISE_MODE_LO       0

// Pointer update modes
`define CISE_MM_PREINC     2'h0
`define CISE_MM_PREDEC     2'h1
`define CISE_MM_POSTINC    2'h2
`define CISE_MM_POSTDEC    2'h3

// Indirect-data port addresses in the file space
`define CISE_IND0_ADDR     7'h00
`define CISE_IND1_ADDR     7'h01

// Reset values
`define CISE_W_RST         8'h00
`define CISE_BANK_RST      5'h00
`define CISE_PAGE_RST      7'h00
`define CISE_OPTION_RST    8'hff
`define CISE_PTR_RST       16'h0000
`define CISE_GIE_BIT       7

// Cycle counts
`define CISE_RET_CYCLES    2

`endif

// [rtl/cise_ptr_unit.v]
// File-select pointer pair with indirect address generation
`timescale 1ns/100ps
`default_nettype none
`include "cise_map.vh"

module cise_ptr_unit (
  input  wire        ref_clk_in,   // Core clock
  input  wire        reset_in,     // Sync reset
  input  wire        clk_en_in,    // Clock enable
  input  wire        sel_in,       // Pointer 0 or 1
  input  wire [1:0]  mode_in,      // Update mode
  input  wire        rel_in,       // Relative offset form
  input  wire [5:0]  offset_in,    // Signed offset
  input  wire        step_in,      // Apply update this cycle
  output wire [15:0] addr_out,     // Effective address
  output wire [15:0] ptr0_out,     // Pointer 0 value
  output wire [15:0] ptr1_out      // Pointer 1 value
);

  reg  [15:0] ptr_q [0:1];
  wire [15:0] cur;
  wire [15:0] inc;
  wire [15:0] dec;
  reg  [15:0] next_ptr;
  reg  [15:0] ea;

  assign cur      = ptr_q[sel_in];
  assign inc      = cur + 16'h0001;
  assign dec      = cur - 16'h0001;
  assign ptr0_out = ptr_q[0];
  assign ptr1_out = ptr_q[1];
  assign addr_out = ea;

  always @* begin
    next_ptr = cur;
    ea       = cur;
    if (rel_in) begin
      ea = cur + {{10{offset_in[5]}}, offset_in};
    end else begin
      case (mode_in)
        `CISE_MM_PREINC: begin
          next_ptr = inc;
          ea       = inc;
        end
        `CISE_MM_PREDEC: begin
          next_ptr = dec;
          ea       = dec;
        end
        `CISE_MM_POSTINC: next_ptr = inc;
        default:          next_ptr = dec;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ptr
      always @(posedge ref_clk_in) begin
        if (reset_in) begin
          ptr_q[g] <= `CISE_PTR_RST;
        end else if (clk_en_in && step_in && (sel_in == g) && !rel_in) begin
          ptr_q[g] <= next_ptr;
        end
      end
    end
  endgenerate

endmodule // cise_ptr_unit

// [rtl/cise_alu.v]
// Combinational result and flag unit for file and literal operations
`timescale 1ns/100ps
`default_nettype none
`include "cise_map.vh"

module cise_alu (
  input  wire [5:0] class_in,    // Instruction class
  input  wire [7:0] w_in,        // Working register
  input  wire [7:0] f_in,        // File or literal operand
  input  wire       carry_in,    // Current carry
  output reg  [7:0] result_out,  // Result byte
  output reg        carry_out,   // New carry
  output reg        wr_z_out,    // Zero flag updated
  output reg        wr_c_out     // Carry flag updated
);

  always @* begin
    result_out = f_in;
    carry_out  = carry_in;
    wr_z_out   = 1'b0;
    wr_c_out   = 1'b0;
    case (class_in)
      `CISE_OP_ORL,
      `CISE_OP_ORF: begin
        result_out = w_in | f_in;
        wr_z_out   = 1'b1;
      end
      `CISE_OP_INCREMENT_FILE_OP: begin
        result_out = f_in + 8'h01;
        wr_z_out   = 1'b1;
      end
      `CISE_OP_LSL: begin
        result_out = {f_in[6:0], 1'b0};
        carry_out  = f_in[7];
        wr_z_out   = 1'b1;
        wr_c_out   = 1'b1;
      end
      `CISE_OP_LSR: begin
        result_out = {1'b0, f_in[7:1]};
        carry_out  = f_in[0];
        wr_z_out   = 1'b1;
        wr_c_out   = 1'b1;
      end
      `CISE_OP_MOVE_FILE_OP,
      `CISE_OP_ILOAD,
      `CISE_OP_ILOADK: begin
        wr_z_out = 1'b1;
      end
      `CISE_OP_RLC: begin
        result_out = {f_in[6:0], carry_in};
        carry_out  = f_in[7];
        wr_c_out   = 1'b1;
      end
      `CISE_OP_RRC: begin
        result_out = {carry_in, f_in[7:1]};
        carry_out  = f_in[0];
        wr_c_out   = 1'b1;
      end
      default: begin
        result_out = f_in;
      end
    endcase
  end

endmodule // cise_alu

// [rtl/cise_exec.v]
// Execution unit for one slice of an 8-bit core instruction set
`timescale 1ns/100ps
`default_nettype none
`include "cise_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - OR literal into W, zero flag
// - Destination bit picks W or file
// - OR-file and increment update zero only
// - Left shift: bit7 to carry, zero in
// - Right shift: bit0 to carry, zero in
// - Move file in one cycle, zero flag
// - Two-bit mode picks pointer update
// - Relative offset keeps pointer unchanged
// - Indirect port redirects through pointer
// - Pointers are 16 bits, wrapping
// - Indirect loads update zero; indirect stores touch no flags
// - Bank literal load, no flags
// - Page latch literal load, no flags
// - Literal into W, one cycle
// - W into file, no flags
// - W into option register, no flags
// - Software reset clears reset-instruction flag
// - Interrupt return pops, sets global enable
// - Subroutine return pops, two cycles
// - Literal return loads W, two cycles
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
module cise_exec (
  input  wire        ref_clk_in,          // Core clock, 125 MHz
  input  wire        reset_in,            // Sync reset, active high
  input  wire        clk_en_in,           // Freezes all state when low
  input  wire        instr_valid_in,      // Instruction word present
  input  wire [13:0] instr_in,            // Instruction word
  input  wire [7:0]  file_rdata_in,       // Direct file read data
  input  wire [7:0]  data_rdata_in,       // Indirect data read data
  input  wire        carry_in,            // Status carry
  input  wire        zero_in,             // Status zero
  input  wire [14:0] stack_top_in,        // Return stack top
  input  wire [7:0]  interrupt_control_in,// Interrupt control register
  output reg         busy_out,            // Second cycle of a return
  output reg  [6:0]  file_addr_out,       // Direct file address
  output reg         file_we_out,         // Direct file write strobe
  output reg  [7:0]  file_wdata_out,      // Direct file write data
  output reg  [15:0] data_addr_out,       // Indirect data address
  output reg         data_we_out,         // Indirect data write strobe
  output reg  [7:0]  data_wdata_out,      // Indirect data write data
  output reg  [7:0]  w_out,               // Working register
  output reg         carry_we_out,        // Carry update strobe
  output reg         carry_out,           // New carry
  output reg         zero_we_out,         // Zero update strobe
  output reg         zero_out,            // New zero
  output reg  [4:0]  bank_select_out,     // Bank select register
  output reg  [6:0]  pc_high_latch_out,   // Program counter high latch
  output reg  [7:0]  option_out,          // Option configuration register
  output reg         pc_load_out,         // Program counter load strobe
  output reg  [14:0] pc_value_out,        // Program counter load value
  output reg         stack_pop_out,       // Return stack pop strobe
  output reg         interrupt_control_reg_we_out,       // Interrupt control write strobe
  output reg  [7:0]  interrupt_control_reg_wdata_out,    // Interrupt control write data
  output reg         soft_reset_out,      // Device reset request
  output reg         reset_instr_flag_out,// Reset-instruction indicator
  output reg  [15:0] file_select_pointer0_out, // Pointer 0
  output reg  [15:0] file_select_pointer1_out  // Pointer 1
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [5:0]  op_class;
  wire        dest_file;
  wire [6:0]  f_addr;
  wire [7:0]  lit;
  wire        is_ind;
  wire        is_rel;
  wire        is_ret;
  wire        ind_port;
  wire        exec;
  wire [15:0] ind_addr;
  wire [15:0] ptr0;
  wire [15:0] ptr1;
  wire [7:0]  f_read;
  wire [7:0]  operand;
  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_wz;
  wire        alu_wc;
  reg         ret_wait_q;
  reg  [5:0]  ret_class_q;
  reg         w_is_w;
  reg         file_dest;
  reg  [7:0]  file_data;
  reg  [15:0] data_addr_d;
  wire [15:0] port_addr;

  assign op_class = instr_in[`CISE_CLASS_HI:`CISE_CLASS_LO];
  assign dest_file = instr_in[`CISE_DEST_BIT];
  assign f_addr    = instr_in[6:0];
  assign lit       = instr_in[7:0];
  assign is_rel    = (op_class == `CISE_OP_ILOADK) || (op_class == `CISE_OP_ISTOREK);
  assign is_ind    = (op_class == `CISE_OP_ILOAD) || (op_class == `CISE_OP_ISTORE) || is_rel;
  assign is_ret    = (op_class == `CISE_OP_RETFI) || (op_class == `CISE_OP_RETURN)
                     || (op_class == `CISE_OP_RETLIT);
  assign exec      = clk_en_in && instr_valid_in && !ret_wait_q;
  assign ind_port  = (f_addr == `CISE_IND0_ADDR) || (f_addr == `CISE_IND1_ADDR);
  assign f_read    = ind_port ? data_rdata_in : file_rdata_in;

  cise_ptr_unit u_ptr (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .clk_en_in  (clk_en_in),
    .sel_in     (instr_in[`CISE_PTR_SEL_BIT]),
    .mode_in    (instr_in[`CISE_MODE_HI:`CISE_MODE_LO]),
    .rel_in     (is_rel),
    .offset_in  (instr_in[5:0]),
    .step_in    (exec && is_ind),
    .addr_out   (ind_addr),
    .ptr0_out   (ptr0),
    .ptr1_out   (ptr1)
  );

  // direct port access uses its own pointer
  assign port_addr = f_addr[0] ? ptr1 : ptr0;

  always @* begin
    data_addr_d = data_addr_out;
    if (is_ind) begin
      data_addr_d = ind_addr;
    end else if (ind_port) begin
      data_addr_d = port_addr;
    end
  end

  // Only the OR-literal class feeds the literal as operand
  assign operand = (op_class == `CISE_OP_ORL) ? lit : f_read;

  cise_alu u_alu (
    .class_in   (op_class),
    .w_in       (w_out),
    .f_in       (is_ind ? data_rdata_in : operand),
    .carry_in   (carry_in),
    .result_out (alu_res),
    .carry_out  (alu_c),
    .wr_z_out   (alu_wz),
    .wr_c_out   (alu_wc)
  );

  always @* begin
    case (op_class)
      `CISE_OP_ORL, `CISE_OP_ILOAD, `CISE_OP_ILOADK: w_is_w = 1'b1;
      `CISE_OP_ORF, `CISE_OP_INCREMENT_FILE_OP, `CISE_OP_LSL, `CISE_OP_LSR,
      `CISE_OP_MOVE_FILE_OP, `CISE_OP_RLC, `CISE_OP_RRC: w_is_w = !dest_file;
      default: w_is_w = 1'b0;
    endcase
  end

  always @* begin
    file_dest = 1'b0;
    file_data = alu_res;
    case (op_class)
      `CISE_OP_ORF, `CISE_OP_INCREMENT_FILE_OP, `CISE_OP_LSL, `CISE_OP_LSR,
      `CISE_OP_MOVE_FILE_OP, `CISE_OP_RLC, `CISE_OP_RRC: begin
        file_dest = dest_file;
      end
      `CISE_OP_STACC: begin
        file_dest = 1'b1;
        file_data = w_out;
      end
      default: begin
        file_dest = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state and strobes
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      w_out                    <= `CISE_W_RST;
      bank_select_out          <= `CISE_BANK_RST;
      pc_high_latch_out        <= `CISE_PAGE_RST;
      option_out               <= `CISE_OPTION_RST;
      reset_instr_flag_out     <= 1'b1;
      ret_wait_q               <= 1'b0;
      ret_class_q              <= `CISE_OP_NOP;
      busy_out                 <= 1'b0;
      file_addr_out            <= 7'h00;
      file_we_out              <= 1'b0;
      file_wdata_out           <= 8'h00;
      data_addr_out            <= 16'h0000;
      data_we_out              <= 1'b0;
      data_wdata_out           <= 8'h00;
      carry_we_out             <= 1'b0;
      carry_out                <= 1'b0;
      zero_we_out              <= 1'b0;
      zero_out                 <= 1'b0;
      pc_load_out              <= 1'b0;
      pc_value_out             <= 15'h0000;
      stack_pop_out            <= 1'b0;
      interrupt_control_reg_we_out            <= 1'b0;
      interrupt_control_reg_wdata_out         <= 8'h00;
      soft_reset_out           <= 1'b0;
      file_select_pointer0_out <= `CISE_PTR_RST;
      file_select_pointer1_out <= `CISE_PTR_RST;
    end else if (clk_en_in) begin
      // Strobes stand one cycle
      file_we_out              <= 1'b0;
      data_we_out              <= 1'b0;
      carry_we_out             <= 1'b0;
      zero_we_out              <= 1'b0;
      pc_load_out              <= 1'b0;
      stack_pop_out            <= 1'b0;
      interrupt_control_reg_we_out            <= 1'b0;
      soft_reset_out           <= 1'b0;
      busy_out                 <= 1'b0;
      // Pointer copies lag one cycle
      file_select_pointer0_out <= ptr0;
      file_select_pointer1_out <= ptr1;
      if (ret_wait_q) begin
        ret_wait_q   <= 1'b0;
        pc_load_out  <= 1'b1;
        pc_value_out <= stack_top_in;
      end else if (exec) begin
        file_addr_out  <= f_addr;
        data_addr_out  <= data_addr_d;
        if (w_is_w) begin
          w_out <= alu_res;
        end

        if (file_dest) begin
          if (ind_port) begin
            data_we_out    <= 1'b1;
            data_wdata_out <= file_data;
          end else begin
            file_we_out    <= 1'b1;
            file_wdata_out <= file_data;
          end
        end

        if (alu_wz) begin
          zero_we_out <= 1'b1;
          zero_out    <= (alu_res == 8'h00);
        end
        if (alu_wc) begin
          carry_we_out <= 1'b1;
          carry_out    <= alu_c;
        end

        case (op_class)
          `CISE_OP_ISTORE, `CISE_OP_ISTOREK: begin
            data_we_out    <= 1'b1;
            data_wdata_out <= w_out;
          end
          `CISE_OP_LDBANK: begin
            bank_select_out <= lit[4:0];
          end
          `CISE_OP_LDPAGE: begin
            pc_high_latch_out <= lit[6:0];
          end
          `CISE_OP_LDACC: begin
            w_out <= lit;
          end
          `CISE_OP_OPTION: begin
            option_out <= w_out;
          end
          `CISE_OP_RESET: begin
            soft_reset_out       <= 1'b1;
            reset_instr_flag_out <= 1'b0;
          end
          `CISE_OP_RETFI, `CISE_OP_RETURN, `CISE_OP_RETLIT: begin
            ret_wait_q    <= 1'b1;
            ret_class_q   <= op_class;
            busy_out      <= 1'b1;
            stack_pop_out <= 1'b1;
            if (op_class == `CISE_OP_RETLIT) begin
              w_out <= lit;
            end
            if (op_class == `CISE_OP_RETFI) begin
              interrupt_control_reg_we_out    <= 1'b1;
              interrupt_control_reg_wdata_out <= interrupt_control_in | (8'h01 << `CISE_GIE_BIT);
            end
          end
          default: begin
            ret_class_q <= ret_class_q;
          end
        endcase
      end
    end
  end

endmodule // cise_exec
`default_nettype wire

// [tb/cise_exec_checker.sv]
// Port-level assertions for the execution slice
`timescale 1ns/100ps
`default_nettype none
`include "cise_map.vh"

module cise_exec_checker (
  input wire logic        ref_clk_in,          // Clock
  input wire logic        reset_in,            // Reset
  input wire logic        clk_en_in,           // Enable
  input wire logic        instr_valid_in,      // Word valid
  input wire logic [13:0] instr_in,            // Word
  input wire logic [7:0]  file_rdata_in,       // File data
  input wire logic        busy_out,            // Return busy
  input wire logic [7:0]  w_out,               // Accumulator
  input wire logic        carry_we_out,        // Carry strobe
  input wire logic        carry_out,           // Carry
  input wire logic        zero_we_out,         // Zero strobe
  input wire logic        zero_out,            // Zero
  input wire logic        file_we_out,         // File strobe
  input wire logic [6:0]  file_addr_out,       // File address
  input wire logic [7:0]  file_wdata_out,      // File data out
  input wire logic [4:0]  bank_select_out,     // Bank
  input wire logic [6:0]  pc_high_latch_out,   // Page latch
  input wire logic [7:0]  option_out,          // Option
  input wire logic        pc_load_out,         // PC load
  input wire logic        stack_pop_out,       // Pop
  input wire logic        interrupt_control_reg_we_out,       // Interrupt_control_reg strobe
  input wire logic [7:0]  interrupt_control_reg_wdata_out,    // Interrupt_control_reg data
  input wire logic        soft_reset_out,      // Reset request
  input wire logic        reset_instr_flag_out // Reset flag
);
  wire logic [5:0] op = instr_in[13:8];
  wire logic       tk = clk_en_in & instr_valid_in & ~busy_out;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////
  a_or_lit_zero: assert property (tk && op == `CISE_OP_ORL |=>
    w_out == ($past(w_out) | $past(instr_in[7:0])) && zero_we_out && zero_out == (w_out == 8'h00) && !carry_we_out)
    else $error("or literal wrong");
  a_lit_acc_load: assert property (tk && op == `CISE_OP_LDACC |=>
    w_out == $past(instr_in[7:0]) && !zero_we_out && !carry_we_out) else $error("literal load wrong");
  a_shl_carry_out: assert property (tk && op == `CISE_OP_LSL && instr_in[6:1] != 6'h00 |=>
    carry_we_out && zero_we_out && carry_out == $past(file_rdata_in[7])) else $error("left shift carry wrong");
  a_shr_carry_out: assert property (tk && op == `CISE_OP_LSR && instr_in[6:1] != 6'h00 |=>
    carry_we_out && zero_we_out && carry_out == $past(file_rdata_in[0])) else $error("right shift carry wrong");
  a_rot_carry_only: assert property (tk && (op == `CISE_OP_RLC || op == `CISE_OP_RRC) |=>
    carry_we_out && !zero_we_out) else $error("rotate flags wrong");
  a_acc_to_file: assert property (tk && op == `CISE_OP_STACC && instr_in[6:1] != 6'h00 |=>
    file_we_out && file_wdata_out == $past(w_out) && file_addr_out == $past(instr_in[6:0]) && !zero_we_out)
    else $error("store to file wrong");
  a_bank_literal: assert property (tk && op == `CISE_OP_LDBANK |=>
    bank_select_out == $past(instr_in[4:0]) && !zero_we_out) else $error("bank load wrong");
  a_page_literal: assert property (tk && op == `CISE_OP_LDPAGE |=>
    pc_high_latch_out == $past(instr_in[6:0])) else $error("page load wrong");
  a_option_from_acc: assert property (tk && op == `CISE_OP_OPTION |=>
    option_out == $past(w_out) && !zero_we_out) else $error("option load wrong");
  a_return_two_cycle: assert property (tk && op == `CISE_OP_RETURN |=>
    stack_pop_out && busy_out ##1 pc_load_out && !busy_out) else $error("return timing wrong");
  a_irq_return_gie: assert property (tk && op == `CISE_OP_RETFI |->
    ##[1:2] interrupt_control_reg_we_out && interrupt_control_reg_wdata_out[`CISE_GIE_BIT]) else $error("enable not set");
  a_soft_reset_flag: assert property (tk && op == `CISE_OP_RESET |=>
    soft_reset_out && !reset_instr_flag_out) else $error("software reset wrong");
endmodule // cise_exec_checker

bind cise_exec cise_exec_checker u_chk (.ref_clk_in, .reset_in, .clk_en_in, .instr_valid_in, .instr_in,
  .file_rdata_in, .busy_out, .w_out, .carry_we_out, .carry_out, .zero_we_out, .zero_out, .file_we_out,
  .file_addr_out, .file_wdata_out, .bank_select_out, .pc_high_latch_out, .option_out, .pc_load_out,
  .stack_pop_out, .interrupt_control_reg_we_out, .interrupt_control_reg_wdata_out, .soft_reset_out, .reset_instr_flag_out);

`default_nettype wire

// [tb/test_cise_exec.sv]
// Directed bench for the execution slice
`timescale 1ns/100ps
`default_nettype none
`include "cise_map.vh"

module test_cise_exec;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        clk_en_in = 1'b1;
  logic        instr_valid_in = 1'b0;
  logic        carry_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic [7:0]  file_rdata_in = 8'h00;
  logic [14:0] stack_top_in = 15'h0000;
  // Data reads return the inverse of file reads, so the two paths differ
  wire  [7:0]  data_rdata_in = ~file_rdata_in;
  logic        busy_out, file_we_out, data_we_out, carry_we_out, carry_out, zero_we_out, zero_out;
  logic        pc_load_out, stack_pop_out, interrupt_control_reg_we_out, soft_reset_out, reset_instr_flag_out;
  logic [6:0]  file_addr_out, pc_high_latch_out;
  logic [7:0]  file_wdata_out, data_wdata_out, w_out, option_out, interrupt_control_reg_wdata_out;
  logic [15:0] data_addr_out, file_select_pointer0_out, file_select_pointer1_out;
  logic [4:0]  bank_select_out;
  logic [14:0] pc_value_out;
  int          n_errors = 0;
  int          n_checks = 0;

  always #4 ref_clk_in = ~ref_clk_in;

  cise_exec dut (.ref_clk_in, .reset_in, .clk_en_in, .instr_valid_in, .instr_in, .file_rdata_in,
    .data_rdata_in, .carry_in, .zero_in(1'b0), .stack_top_in, .interrupt_control_in(8'h00),
    .busy_out, .file_addr_out, .file_we_out, .file_wdata_out, .data_addr_out, .data_we_out, .data_wdata_out,
    .w_out, .carry_we_out, .carry_out, .zero_we_out, .zero_out, .bank_select_out, .pc_high_latch_out,
    .option_out, .pc_load_out, .pc_value_out, .stack_pop_out, .interrupt_control_reg_we_out, .interrupt_control_reg_wdata_out,
    .soft_reset_out, .reset_instr_flag_out, .file_select_pointer0_out, .file_select_pointer1_out);

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic issue(input logic [5:0] c, input logic [7:0] lo, input logic [7:0] f);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= {c, lo};
    file_rdata_in <= f;
  endtask

  // One instruction, outputs settled after its taking edge
  task automatic run(input logic [5:0] c, input logic [7:0] lo, input logic [7:0] f);
    issue(c, lo, f);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic t_literal;
    run(`CISE_OP_LDACC, 8'h5a, 8'h00);
    chk({w_out, zero_we_out, carry_we_out}, {8'h5a, 2'b00});
    run(`CISE_OP_ORL, 8'ha4, 8'h00);
    chk({w_out, zero_we_out, zero_out, carry_we_out}, {8'hfe, 3'b100});
    issue(`CISE_OP_LDACC, 8'h00, 8'h00);
    run(`CISE_OP_ORL, 8'h00, 8'h00);
    chk({w_out, zero_we_out, zero_out}, {8'h00, 2'b11});
  endtask

  task automatic t_file;
    run(`CISE_OP_LDACC, 8'h0c, 8'h00);
    run(`CISE_OP_ORF, 8'ha0, 8'h30);
    chk({file_we_out, file_addr_out, file_wdata_out}, {1'b1, 7'h20, 8'h3c});
    run(`CISE_OP_ORF, 8'h20, 8'h30);
    chk({file_we_out, w_out}, {1'b0, 8'h3c});
    run(`CISE_OP_INCREMENT_FILE_OP, 8'ha0, 8'hff);
    chk({file_wdata_out, zero_we_out, zero_out, carry_we_out}, {8'h00, 3'b110});
    run(`CISE_OP_MOVE_FILE_OP, 8'ha0, 8'h00);
    chk({file_wdata_out, zero_we_out, zero_out, file_we_out}, {8'h00, 3'b111});
    run(`CISE_OP_MOVE_FILE_OP, 8'h20, 8'h81);
    chk({w_out, zero_we_out, zero_out}, {8'h81, 2'b10});
  endtask

  task automatic t_shift;
    logic [5:0]  op [4] = '{`CISE_OP_LSL, `CISE_OP_LSR, `CISE_OP_RLC, `CISE_OP_RRC};
    logic [10:0] ex [4] = '{{8'h2c, 3'b111}, {8'h4b, 3'b101}, {8'h2d, 3'b110}, {8'hcb, 3'b100}};
    carry_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      run(op[i], 8'h20, 8'h96);
      chk({w_out, carry_we_out, carry_out, zero_we_out}, ex[i]);
    end
    run(`CISE_OP_LSL, 8'h20, 8'h80);
    chk({w_out, zero_out, carry_out}, {8'h00, 2'b11});
  endtask

  task automatic t_moves;
    run(`CISE_OP_LDACC, 8'h4f, 8'h00);
    run(`CISE_OP_STACC, 8'h33, 8'h00);
    chk({file_we_out, file_addr_out, file_wdata_out}, {1'b1, 7'h33, 8'h4f});
    run(`CISE_OP_OPTION, 8'h00, 8'h00);
    chk({option_out, zero_we_out, carry_we_out}, {8'h4f, 2'b00});
    run(`CISE_OP_LDBANK, 8'h0f, 8'h00);
    chk(bank_select_out, 5'h0f);
    run(`CISE_OP_LDPAGE, 8'h7f, 8'h00);
    chk(pc_high_latch_out, 7'h7f);
    run(`CISE_OP_NOP, 8'h00, 8'h00);
    chk({w_out, file_we_out, zero_we_out, carry_we_out, busy_out}, {8'h4f, 4'h0});
  endtask

  task automatic t_indirect;
    logic [45:0] s [8] = '{
      {`CISE_OP_ILOAD, 8'h00, 16'h0001, 16'h0001}, {`CISE_OP_ILOAD, 8'h01, 16'h0000, 16'h0000},
      {`CISE_OP_ILOAD, 8'h01, 16'hffff, 16'hffff}, {`CISE_OP_ILOAD, 8'h02, 16'hffff, 16'h0000},
      {`CISE_OP_ISTORE, 8'h43, 16'h0000, 16'hffff}, {`CISE_OP_ISTORE, 8'h40, 16'h0000, 16'h0000},
      {`CISE_OP_ILOADK, 8'h60, 16'hffe0, 16'h0000}, {`CISE_OP_ILOADK, 8'h1f, 16'h001f, 16'h0000}};
    for (int i = 0; i < 8; i++) begin
      run(s[i][45:40], s[i][39:32], 8'h00);
      chk(data_addr_out, s[i][31:16]);
      chk({data_we_out, zero_we_out, carry_we_out}, s[i][45:40] == `CISE_OP_ISTORE ? 3'b100 : 3'b010);
      @(posedge ref_clk_in);
      #1;
      chk(s[i][38] ? file_select_pointer1_out : file_select_pointer0_out, s[i][15:0]);
    end
    run(`CISE_OP_LDACC, 8'h66, 8'h00);
    run(`CISE_OP_STACC, 8'h00, 8'h00);
    chk({file_we_out, data_we_out, data_wdata_out}, {2'b01, 8'h66});
    chk(data_addr_out, 16'h0000);
    run(`CISE_OP_MOVE_FILE_OP, 8'h00, 8'h88);
    chk(w_out, 8'h77);
  endtask

  // Return, then a held instruction that must wait out the busy cycle
  task automatic t_ret(input logic [5:0] c, input logic [7:0] k, input logic [7:0] wexp);
    logic seen;
    stack_top_in <= {k, 7'h35};
    issue(c, k, 8'h00);
    issue(`CISE_OP_LDACC, 8'h11, 8'h00);
    #1;
    chk({stack_pop_out, busy_out, pc_load_out, zero_we_out, carry_we_out}, 5'b11000);
    seen = interrupt_control_reg_we_out & interrupt_control_reg_wdata_out[`CISE_GIE_BIT];
    @(posedge ref_clk_in);
    #1;
    chk({pc_load_out, pc_value_out}, {1'b1, k, 7'h35});
    chk(w_out, wexp);
    seen = seen | (interrupt_control_reg_we_out & interrupt_control_reg_wdata_out[`CISE_GIE_BIT]);
    chk(seen, c == `CISE_OP_RETFI);
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    #1;
    chk(w_out, 8'h11);
  endtask

  task automatic t_soft_reset;
    run(`CISE_OP_RESET, 8'h00, 8'h00);
    chk({soft_reset_out, reset_instr_flag_out}, 2'b10);
    reset_in <= 1'b1;
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    clk_en_in <= 1'b0;
    run(`CISE_OP_LDACC, 8'h99, 8'h00);
    chk({reset_instr_flag_out, w_out, option_out}, {1'b1, `CISE_W_RST, `CISE_OPTION_RST});
    clk_en_in <= 1'b1;
  endtask

  ////////////////////////////////////////
  initial begin
    fork
      begin
        #20000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
      end
    join_none
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    #1;
    chk({option_out, reset_instr_flag_out, bank_select_out}, {`CISE_OPTION_RST, 1'b1, `CISE_BANK_RST});
    chk({w_out, pc_high_latch_out}, {`CISE_W_RST, `CISE_PAGE_RST});
    t_literal;
    t_file;
    t_shift;
    t_moves;
    t_indirect;
    t_ret(`CISE_OP_RETURN, 8'h00, 8'h77);
    t_ret(`CISE_OP_RETLIT, 8'h42, 8'h42);
    t_ret(`CISE_OP_RETFI, 8'h00, 8'h11);
    t_soft_reset;
    end_sim;
  end
endmodule // test_cise_exec

`default_nettype wire
